//--- core/mbl_pkg.sv
// constants, register map and carrier types of the fabric mailbox link
// assumes one 50 MHz clock and a plain strobe register port with 8-bit byte addresses
//
// What this block does
// - the block holds an eight-entry transmit fifo and an eight-entry receive fifo of bytes behind its register port.
// - outside loopback every byte the fabric master writes is carried to the peer block, whose request line tells the controller a byte waits.
// - every byte travels with a marker as bit 8 of a nine-bit path so the receiver can find packet starts.
// - a byte or word write to the frame-start registers enqueues its bytes with the marker set.
// - a byte or word write to the plain data registers enqueues its bytes with the marker clear.
// - status bit 7 shows whether the next receive byte carries the marker.
// - receive and transmit dma request lines give the dma engine flow control.
// - the register, control and link logic and both fifos share the single clock here.
// - after power-up the soft reset bit is one, control holds 2, status reads 5 and other registers are zero; the block stays in reset until software releases it.
// - bit 15 of the soft reset register holds the block in reset while one and resets to one.
// - one interrupt output asserts only for conditions whose enable bits are set.
package mbl_pkg;
   localparam int FIFO_DEPTH     = 8;
   localparam int PTR_W          = 3;
   localparam int CNT_W          = 4;
   localparam logic [CNT_W-1:0] CNT_FULL  = 4'h8;
   localparam logic [CNT_W-1:0] CNT_WORD  = 4'h4;  // most entries allowing a word write
   localparam logic [2:0]       WORD_BYTES = 3'h4;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_INT_EN     = 8'h08;
   localparam logic [7:0] ADDR_INT_STAT   = 8'h0c;
   localparam logic [7:0] ADDR_PLAIN8     = 8'h10;
   localparam logic [7:0] ADDR_PLAIN32    = 8'h14;
   localparam logic [7:0] ADDR_MARK8      = 8'h18;
   localparam logic [7:0] ADDR_MARK32     = 8'h1c;
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h20;
   localparam logic [7:0] ADDR_RX_DATA    = 8'h24;

   // control fields
   localparam int CTRL_ENABLE   = 0;
   localparam int CTRL_LOOPBACK = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam int SOFT_RESET_BIT = 15;

   // status fields
   localparam int ST_TX_OK      = 0;
   localparam int ST_RX_OK      = 1;
   localparam int ST_TX_WORD_OK = 2;
   localparam int ST_TX_FULL    = 3;
   localparam int ST_RX_MARK    = 7;

   // interrupt condition bits
   localparam int EV_W         = 4;
   localparam int EV_RX_NEMPTY = 0;
   localparam int EV_TX_NFULL  = 1;
   localparam int EV_TX_OVFL   = 2;
   localparam int EV_RX_UNFL   = 3;

   typedef struct packed {
      logic       mark;
      logic [7:0] data;
   } mbl_byte_s;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_DROP = 2'b10
   } mbl_tx_state_e;
endpackage : mbl_pkg

//--- core/mbl_fifo.sv
// eight-entry nine-bit fifo with a registered head word
// assumes push is never given when full nor pop when empty; one clock, sync reset
module mbl_fifo
   import mbl_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               push_i,
   input  mbl_pkg::mbl_byte_s      wdata_i,
   input  wire logic               pop_i,
   output mbl_pkg::mbl_byte_s      head_o,
   output logic [mbl_pkg::CNT_W-1:0] count_o
);
   mbl_byte_s             mem [FIFO_DEPTH];
   logic [PTR_W-1:0]      wr_ptr_reg;
   logic [PTR_W-1:0]      rd_ptr_reg;
   logic [PTR_W-1:0]      rd_ptr_next;
   logic [CNT_W-1:0]      count_reg;

   assign rd_ptr_next = pop_i ? rd_ptr_reg + 3'h1 : rd_ptr_reg;
   assign count_o     = count_reg;

   // storage has no reset, only pointers, fill level and head do
   always_ff @(posedge clk_i) begin
      if (push_i) begin
         mem[wr_ptr_reg] <= wdata_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push_i) begin
            wr_ptr_reg <= wr_ptr_reg + 3'h1;
         end
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_reg + {3'h0, push_i} - {3'h0, pop_i};
      end
   end

   // head is a register: bypass the write when it lands on the next head slot
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_o <= '0;
      end else if (push_i && wr_ptr_reg == rd_ptr_next) begin
         head_o <= wdata_i;
      end else begin
         head_o <= mem[rd_ptr_next];
      end
   end
endmodule : mbl_fifo

//--- core/mbl_link.sv
// top of the fabric mailbox link: register port, marker logic, fifos, peer handshake
// assumes the peer block drives its lines from another clock; those pass two flip-flops here
//
// The implementer's own choices: the strobed register port and the placing of the registers.
module mbl_link
   import mbl_pkg::*;
(
   input  wire logic          REF_CLK_I,
   input  wire logic          RST_I,
   input  wire logic [7:0]    ADDR_I,
   input  wire logic [31:0]   WDATA_I,
   input  wire logic          WR_I,
   input  wire logic          RD_I,
   output logic [31:0]        RDATA_O,
   output logic               MAILBOX_IRQ_OUT_O,
   output logic               RX_DMA_REQUEST_O,
   output logic               TX_DMA_REQUEST_O,
   output mbl_pkg::mbl_byte_s TX_BYTE_O,
   output logic               TX_REQ_O,
   input  wire logic          TX_ACK_I,
   input  mbl_pkg::mbl_byte_s RX_BYTE_I,
   input  wire logic          RX_REQ_I,
   output logic               RX_ACK_O
);
   logic                   soft_reset_reg;
   logic                   blk_rst;
   logic [1:0]             ctrl_reg;
   logic [EV_W-1:0]        int_en_reg;
   logic [EV_W-1:0]        int_stat_reg;
   logic [EV_W-1:0]        events;
   logic [31:0]            stage_reg;
   logic [2:0]             stage_cnt_reg;
   logic                   stage_mark_reg;
   logic                   tx_push;
   mbl_byte_s              tx_wdata;
   logic                   tx_pop;
   mbl_byte_s              tx_head;
   logic [CNT_W-1:0]       tx_cnt;
   logic                   rx_push;
   mbl_byte_s              rx_wdata;
   logic                   rx_pop;
   mbl_byte_s              rx_head;
   logic [CNT_W-1:0]       rx_cnt;
   logic                   tx_full;
   logic                   tx_empty;
   logic                   rx_full;
   logic                   rx_empty;
   logic                   enabled;
   logic                   loopback;
   logic                   wr_byte;
   logic                   wr_word;
   logic                   wr_mark;
   logic                   byte_ok;
   logic                   word_ok;
   logic                   tx_ovfl;
   logic                   rx_unfl;
   logic [31:0]            rdata_next;
   logic                   tx_ack_meta;
   logic                   tx_ack_sync;
   logic                   rx_req_meta;
   logic                   rx_req_sync;
   mbl_byte_s              rx_byte_meta;
   mbl_byte_s              rx_byte_sync;
   mbl_tx_state_e          tx_state_reg;
   mbl_byte_s              tx_byte_reg;
   logic                   rx_ack_reg;

   // soft reset register sits outside the block reset so software can release it
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         soft_reset_reg <= 1'b1;
      end else if (WR_I && ADDR_I == ADDR_SOFT_RESET) begin
         soft_reset_reg <= WDATA_I[SOFT_RESET_BIT];
      end
   end

   assign blk_rst  = RST_I || soft_reset_reg;
   assign enabled  = ctrl_reg[CTRL_ENABLE] && !blk_rst;    // dma lines drop at once
   assign loopback = ctrl_reg[CTRL_LOOPBACK];
   assign tx_full  = tx_cnt == CNT_FULL;
   assign tx_empty = tx_cnt == '0;
   assign rx_full  = rx_cnt == CNT_FULL;
   assign rx_empty = rx_cnt == '0;

   // write decode: which data register, and whether it marks a frame start
   assign wr_byte = WR_I && (ADDR_I == ADDR_PLAIN8 || ADDR_I == ADDR_MARK8);
   assign wr_word = WR_I && (ADDR_I == ADDR_PLAIN32 || ADDR_I == ADDR_MARK32);
   assign wr_mark = ADDR_I == ADDR_MARK8 || ADDR_I == ADDR_MARK32;
   assign byte_ok = stage_cnt_reg == '0 && !tx_full;
   assign word_ok = stage_cnt_reg == '0 && tx_cnt <= CNT_WORD;
   assign tx_ovfl = (wr_byte && !byte_ok) || (wr_word && !word_ok);

   // control and enable registers
   always_ff @(posedge REF_CLK_I) begin
      if (blk_rst) begin
         ctrl_reg   <= CTRL_RESET;
         int_en_reg <= '0;
      end else if (WR_I && ADDR_I == ADDR_CTRL) begin
         ctrl_reg   <= WDATA_I[1:0];
      end else if (WR_I && ADDR_I == ADDR_INT_EN) begin
         int_en_reg <= WDATA_I[EV_W-1:0];
      end
   end

   // word staging: a word is taken in one cycle and fed to the fifo low byte first
   always_ff @(posedge REF_CLK_I) begin
      if (blk_rst) begin
         stage_reg      <= '0;
         stage_cnt_reg  <= '0;
         stage_mark_reg <= 1'b0;
      end else if (wr_word && word_ok) begin
         stage_reg      <= WDATA_I;
         stage_cnt_reg  <= WORD_BYTES;
         stage_mark_reg <= wr_mark;
      end else if (stage_cnt_reg != '0) begin
         stage_reg      <= {8'h00, stage_reg[31:8]};
         stage_cnt_reg  <= stage_cnt_reg - 3'h1;
      end
   end

   // transmit fifo feed: byte writes go straight in, otherwise the stage drains
   always_comb begin
      tx_push  = 1'b0;
      tx_wdata = '0;
      if (wr_byte && byte_ok) begin
         tx_push  = 1'b1;
         tx_wdata = '{mark: wr_mark, data: WDATA_I[7:0]};
      end else if (stage_cnt_reg != '0) begin
         tx_push  = 1'b1;
         tx_wdata = '{mark: stage_mark_reg, data: stage_reg[7:0]};
      end
   end

   // both fifos, eight nine-bit entries each
   mbl_fifo u_tx_fifo (
      .clk_i   (REF_CLK_I),
      .rst_i   (blk_rst),
      .push_i  (tx_push),
      .wdata_i (tx_wdata),
      .pop_i   (tx_pop),
      .head_o  (tx_head),
      .count_o (tx_cnt)
   );

   mbl_fifo u_rx_fifo (
      .clk_i   (REF_CLK_I),
      .rst_i   (blk_rst),
      .push_i  (rx_push),
      .wdata_i (rx_wdata),
      .pop_i   (rx_pop),
      .head_o  (rx_head),
      .count_o (rx_cnt)
   );

   // peer lines come from another clock: two flip-flops before any use
   // the peer byte passes the same two stages as the request and is seen in the same cycle
   always_ff @(posedge REF_CLK_I) begin
      if (blk_rst) begin
         tx_ack_meta <= 1'b0;
         tx_ack_sync <= 1'b0;
         rx_req_meta <= 1'b0;
         rx_req_sync <= 1'b0;
         rx_byte_meta <= '0;
         rx_byte_sync <= '0;
      end else begin
         tx_ack_meta <= TX_ACK_I;
         tx_ack_sync <= tx_ack_meta;
         rx_req_meta <= RX_REQ_I;
         rx_req_sync <= rx_req_meta;
         rx_byte_meta <= RX_BYTE_I;
         rx_byte_sync <= rx_byte_meta;
      end
   end

   // outbound four-phase handshake; the byte is held until the request is dropped
   always_ff @(posedge REF_CLK_I) begin
      if (blk_rst) begin
         tx_state_reg <= TX_IDLE;
         tx_byte_reg  <= '0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               if (enabled && !loopback && !tx_empty && !tx_ack_sync) begin
                  tx_byte_reg  <= tx_head;
                  tx_state_reg <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (tx_ack_sync) begin
                  tx_state_reg <= TX_DROP;
               end
            end
            TX_DROP: begin
               if (!tx_ack_sync) begin
                  tx_state_reg <= TX_IDLE;
               end
            end
            default: begin
               tx_state_reg <= TX_IDLE;
            end
         endcase
      end
   end

   // loopback moves the transmit head straight into the receive fifo
   assign tx_pop = (tx_state_reg == TX_IDLE && enabled && !tx_empty)
                   && (loopback ? !rx_full : !tx_ack_sync);

   // inbound handshake: peer data is stable while its request stands
   always_ff @(posedge REF_CLK_I) begin
      if (blk_rst) begin
         rx_ack_reg <= 1'b0;
      end else if (rx_req_sync && !rx_ack_reg && enabled && !loopback && !rx_full) begin
         rx_ack_reg <= 1'b1;
      end else if (!rx_req_sync) begin
         rx_ack_reg <= 1'b0;
      end
   end

   always_comb begin
      rx_push  = 1'b0;
      rx_wdata = rx_byte_sync;
      if (loopback) begin
         rx_push  = tx_pop;
         rx_wdata = tx_head;
      end else if (rx_req_sync && !rx_ack_reg && enabled && !rx_full) begin
         rx_push  = 1'b1;
      end
   end

   assign rx_pop  = RD_I && ADDR_I == ADDR_RX_DATA && !rx_empty;
   assign rx_unfl = RD_I && ADDR_I == ADDR_RX_DATA && rx_empty;

   // interrupt conditions: set wins over a write-one clear in the same cycle
   assign events = {rx_unfl, tx_ovfl, !tx_full, !rx_empty};
   always_ff @(posedge REF_CLK_I) begin
      if (blk_rst) begin
         int_stat_reg <= '0;
      end else if (WR_I && ADDR_I == ADDR_INT_STAT) begin
         int_stat_reg <= (int_stat_reg & ~WDATA_I[EV_W-1:0]) | events;
      end else begin
         int_stat_reg <= int_stat_reg | events;
      end
   end

   assign MAILBOX_IRQ_OUT_O = !blk_rst && |(int_stat_reg & int_en_reg);
   assign RX_DMA_REQUEST_O  = enabled && !rx_empty;
   assign TX_DMA_REQUEST_O  = enabled && byte_ok;
   assign TX_BYTE_O         = tx_byte_reg;
   assign TX_REQ_O          = tx_state_reg == TX_WAIT;
   assign RX_ACK_O          = rx_ack_reg;

   // read mux; unmapped addresses and write-only data registers read zero
   always_comb begin
      rdata_next = '0;
      case (ADDR_I)
         ADDR_CTRL:       rdata_next[1:0] = ctrl_reg;
         ADDR_STATUS: begin
            rdata_next[ST_TX_OK]      = byte_ok;
            rdata_next[ST_RX_OK]      = !rx_empty;
            rdata_next[ST_TX_WORD_OK] = word_ok;
            rdata_next[ST_TX_FULL]    = tx_full;
            rdata_next[ST_RX_MARK]    = !rx_empty && rx_head.mark;
         end
         ADDR_INT_EN:     rdata_next[EV_W-1:0] = int_en_reg;
         ADDR_INT_STAT:   rdata_next[EV_W-1:0] = int_stat_reg;
         ADDR_SOFT_RESET: rdata_next[SOFT_RESET_BIT] = soft_reset_reg;
         ADDR_RX_DATA:    rdata_next[8:0] = rx_empty ? 9'h000 : rx_head;
         default:         rdata_next = '0;
      endcase
   end

   // read data stand only in the cycle after the read strobe
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || !RD_I) begin
         RDATA_O <= '0;
      end else begin
         RDATA_O <= rdata_next;
      end
   end

   // checks
   sequence s_four_marked;
      (tx_push && tx_wdata.mark)[*4];
   endsequence

   sequence s_four_plain;
      (tx_push && !tx_wdata.mark)[*4];
   endsequence

   property p_mark_byte;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      (WR_I && ADDR_I == ADDR_MARK8 && byte_ok)
         |-> tx_push && tx_wdata.mark && tx_wdata.data == WDATA_I[7:0];
   endproperty
   a_mark_byte: assert property (p_mark_byte) else $error("marker byte not enqueued");

   property p_mark_word;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      (WR_I && ADDR_I == ADDR_MARK32 && word_ok) |=> s_four_marked ##1 !tx_push || wr_byte;
   endproperty
   a_mark_word: assert property (p_mark_word) else $error("marker word not four bytes");

   property p_plain_word;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      (WR_I && ADDR_I == ADDR_PLAIN32 && word_ok) |=> s_four_plain;
   endproperty
   a_plain_word: assert property (p_plain_word) else $error("plain word marked");

   property p_status_mark;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      (RD_I && ADDR_I == ADDR_STATUS && !rx_empty)
         |=> RDATA_O[ST_RX_MARK] == $past(rx_head.mark);
   endproperty
   a_status_mark: assert property (p_status_mark) else $error("status bit 7 wrong");

   property p_irq_gate;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (int_en_reg == '0 || soft_reset_reg) |-> !MAILBOX_IRQ_OUT_O;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_soft_hold;
      @(posedge REF_CLK_I) disable iff (RST_I)
      soft_reset_reg[*2] |-> tx_cnt == '0 && rx_cnt == '0 && !TX_REQ_O && !RX_ACK_O;
   endproperty
   a_soft_hold: assert property (p_soft_hold) else $error("block active in reset");

   property p_dma_tx;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      tx_full |-> !TX_DMA_REQUEST_O ##1 1'b1;
   endproperty
   a_dma_tx: assert property (p_dma_tx) else $error("tx dma request while full");

   property p_tx_hold;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      (TX_REQ_O && !tx_ack_sync) |=> $stable(TX_BYTE_O);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte moved during request");

   property p_rx_once;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      (rx_push && !loopback) |=> RX_ACK_O && !rx_push;
   endproperty
   a_rx_once: assert property (p_rx_once) else $error("peer byte taken twice");

   property p_ovfl_flag;
      @(posedge REF_CLK_I) disable iff (blk_rst)
      tx_ovfl |=> int_stat_reg[EV_TX_OVFL];
   endproperty
   a_ovfl_flag: assert property (p_ovfl_flag) else $error("overflow not flagged");
endmodule : mbl_link

//--- verif/mbl_peer.sv
// behavioural peer mailbox: takes link bytes by four-phase ack and sends bytes back
// assumes the link and this model share the 50 MHz clock; the testbench sets stall
module mbl_peer
   import mbl_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  mbl_pkg::mbl_byte_s tx_byte_i,
   input  wire logic          tx_req_i,
   output logic               tx_ack_o,
   output mbl_pkg::mbl_byte_s rx_byte_o,
   output logic               rx_req_o,
   input  wire logic          rx_ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic      stall;   // holds the ack back, as a slow controller would
   mbl_byte_s got[$];  // bytes taken from the link, oldest first

   // idle link lines at time zero
   initial begin
      stall = 1'b0;
      tx_ack_o = 1'b0;
      rx_req_o = 1'b0;
      rx_byte_o = 9'h1ff;
   end

   // one byte per request; ack drops only after the request falls
   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_ack_o <= 1'b0;
      end else if (tx_req_i && !tx_ack_o && !stall) begin
         got.push_back(tx_byte_i);
         tx_ack_o <= 1'b1;
      end else if (!tx_req_i) begin
         tx_ack_o <= 1'b0;
      end
   end

   // byte held until ack is seen, then released to its inverse
   task automatic send(input mbl_byte_s b, output bit ok);
      int n;
      ok = 1'b0;
      @(posedge clk_i);
      rx_byte_o <= b;
      rx_req_o <= 1'b1;
      for (n = 0; n < 50 && !ok; n++) begin
         @(posedge clk_i);
         ok = (rx_ack_i === 1'b1);
      end
      rx_req_o <= 1'b0;
      rx_byte_o <= ~b;   // stale data must not look valid
      for (n = 0; n < 50 && rx_ack_i !== 1'b0; n++) begin
         @(posedge clk_i);
      end
   endtask : send
endmodule : mbl_peer

//--- verif/tb_top.sv
// self-checking bench of the mailbox link against a behavioural peer
// assumes one 50 MHz clock and the strobe register port of the package map
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mbl_pkg::*;
   logic        clk, rst, wr_s, rd_s, irq, rx_dma, tx_dma, tx_req, tx_ack, rx_req, rx_ack;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   mbl_byte_s   tx_byte, rx_byte;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          base;
   bit          ok;

   mbl_link dut_u (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .MAILBOX_IRQ_OUT_O(irq),
      .RX_DMA_REQUEST_O(rx_dma), .TX_DMA_REQUEST_O(tx_dma), .TX_BYTE_O(tx_byte),
      .TX_REQ_O(tx_req), .TX_ACK_I(tx_ack), .RX_BYTE_I(rx_byte), .RX_REQ_I(rx_req),
      .RX_ACK_O(rx_ack));
   mbl_peer peer_u (.clk_i(clk), .rst_i(rst), .tx_byte_i(tx_byte), .tx_req_i(tx_req),
      .tx_ack_o(tx_ack), .rx_byte_o(rx_byte), .rx_req_o(rx_req), .rx_ack_i(rx_ack));

   // 20 ns clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // a hang is cut short at 20000 cycles, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic wait_peer(input int n);
      for (int k = 0; k < 200 && peer_u.got.size() < n; k++) @(posedge clk);
      chk("peer count", n, peer_u.got.size());
   endtask : wait_peer

   task automatic chk_peer(input int i, input logic [8:0] e);
      chk("peer byte", {23'h0, e}, {23'h0, peer_u.got[i]});
   endtask : chk_peer

   task automatic t_reset();
      #1 chk("outputs", 32'h0, {tx_dma, rx_dma, irq, tx_req, rx_ack});
      rd(ADDR_SOFT_RESET, v);
      chk("soft reset", 32'h8000, v);
      wr(ADDR_SOFT_RESET, 32'h0);
      rd(ADDR_CTRL, v);
      chk("ctrl", 32'h2, v);
      wr(ADDR_CTRL, 32'h3);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_STATUS, v);
      chk("status", 32'h5, v);
      rd(8'h30, v);
      chk("unmapped", 32'h0, v);
      #1 chk("tx dma", 32'h1, tx_dma);
      $display("test reset done");
   endtask : t_reset

   task automatic t_tx_bytes();
      base = peer_u.got.size();
      wr(ADDR_MARK8, 32'h5a);
      wr(ADDR_PLAIN8, 32'ha5);
      wait_peer(base + 2);
      chk_peer(base, 9'h15a);
      chk_peer(base + 1, 9'h0a5);
      $display("test tx bytes done");
   endtask : t_tx_bytes

   task automatic t_tx_words();
      base = peer_u.got.size();
      wr(ADDR_MARK32, 32'h44332211);
      wait_peer(base + 4);
      wr(ADDR_PLAIN32, 32'hddccbbaa);
      wait_peer(base + 8);
      for (int i = 0; i < 4; i++) chk_peer(base + i, 9'h100 | (9'h011 * (i + 1)));
      for (int i = 0; i < 4; i++) chk_peer(base + 4 + i, 9'h0aa + 9'h11 * i);
      $display("test tx words done");
   endtask : t_tx_words

   task automatic t_rx_irq();
      peer_u.send(9'h13c, ok);
      chk("send ack", 32'h1, ok);
      peer_u.send(9'h0c3, ok);
      chk("send ack", 32'h1, ok);
      rd(ADDR_STATUS, v);
      chk("status rx", 32'h82, v & 32'h82);
      #1 chk("rx dma", 32'h1, rx_dma);
      rd(ADDR_RX_DATA, v);
      chk("rx data", 32'h13c, v);
      rd(ADDR_STATUS, v);
      chk("status rx", 32'h02, v & 32'h82);
      rd(ADDR_RX_DATA, v);
      chk("rx data", 32'h0c3, v);
      rd(ADDR_RX_DATA, v);
      chk("rx empty", 32'h0, v);
      #1 chk("irq masked", 32'h0, irq);
      wr(ADDR_INT_EN, 32'h8);
      #1 chk("irq", 32'h1, irq);
      wr(ADDR_INT_EN, 32'h0);
      wr(ADDR_INT_STAT, 32'h8);
      rd(ADDR_INT_STAT, v);
      chk("int clear", 32'h0, v & 32'h8);
      chk("irq off", 32'h0, irq);
      $display("test rx irq done");
   endtask : t_rx_irq

   // one byte waits in the link stage, eight fill the fifo, the tenth is refused
   task automatic t_fill();
      base = peer_u.got.size();
      peer_u.stall = 1'b1;
      for (int i = 0; i < 9; i++) wr(ADDR_PLAIN8, 32'h80 + i);
      rd(ADDR_STATUS, v);
      chk("status full", 32'h8, v & 32'h9);
      chk("tx dma full", 32'h0, tx_dma);
      wr(ADDR_PLAIN8, 32'hee);
      rd(ADDR_INT_STAT, v);
      chk("overflow", 32'h4, v & 32'h4);
      peer_u.stall = 1'b0;
      wait_peer(base + 9);
      repeat (20) @(posedge clk);
      chk("peer count", base + 9, peer_u.got.size());
      for (int i = 0; i < 9; i++) chk_peer(base + i, 9'h080 + i);
      $display("test fill done");
   endtask : t_fill

   // soft reset in mid-run, then one loopback byte before the link is handed back
   task automatic t_soft();
      base = peer_u.got.size();
      wr(ADDR_INT_EN, 32'h2);
      #1 chk("irq tx non-full", 32'h1, irq);
      wr(ADDR_SOFT_RESET, 32'h8000);
      #1 chk("outputs held", 32'h0, {tx_dma, rx_dma, irq});
      wr(ADDR_INT_EN, 32'h1);
      rd(ADDR_INT_EN, v);
      chk("int en held", 32'h0, v);
      rd(ADDR_CTRL, v);
      chk("ctrl held", 32'h2, v);
      wr(ADDR_SOFT_RESET, 32'h0);
      wr(ADDR_CTRL, 32'h3);
      wr(ADDR_MARK8, 32'h77);
      rd(ADDR_STATUS, v);
      chk("loop status", 32'h82, v & 32'h82);
      rd(ADDR_RX_DATA, v);
      chk("loop data", 32'h177, v);
      chk("loop peer", base, peer_u.got.size());
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_STATUS, v);
      chk("status", 32'h5, v);
      $display("test soft reset done");
   endtask : t_soft

   // main sequence
   initial begin
      rst = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_tx_bytes();
      t_tx_words();
      t_rx_irq();
      t_fill();
      t_soft();
      end_of_test();
   end
endmodule : tb_top
